/* shared/mem_seq_pkg.sv */
// constants shared by the memory operation sequencer
package mem_seq_pkg;
   // system bus field widths and axi address width
   localparam int DEST_W = 4;
   localparam int SRC_W  = 3;
   localparam int OP_W   = 2;
   localparam int DATA_W = 16;
   localparam int AXI_AW = 4;

   // operation codes
   localparam logic [1:0] OP_NOP   = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ  = 2'h2;
   localparam logic [1:0] OP_RSO   = 2'h3;

   // delay-line instants as timer ticks from operation start
   localparam logic [4:0] D4_TICK        = 5'h01;
   localparam logic [4:0] D11_TICK       = 5'h02;
   localparam logic [4:0] D14_TICK       = 5'h03;
   localparam logic [4:0] D16_TICK       = 5'h04;
   localparam logic [4:0] READ_DONE_TICK = 5'h04;
   localparam logic [4:0] READ_END_TICK  = 5'h06;
   localparam logic [4:0] RSO_END_TICK   = 5'h0A;
   localparam logic [4:0] WRITE_END_TICK = 5'h04;

   // write data-phase time-out
   localparam real CLOCK_PERIOD_NS      = 20.0;
   localparam real WRITE_TIMEOUT_MS     = 6.4;
   localparam int  WRITE_TIMEOUT_CYCLES = int'(WRITE_TIMEOUT_MS * 1.0e6 / CLOCK_PERIOD_NS);

   // register map
   localparam logic [3:0] CTRL_OFFSET   = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;
   localparam int CTRL_MODNUM_LSB  = 0;
   localparam int CTRL_BOARD_LSB   = 8;
   localparam logic [3:0] MODNUM_RESET = 4'h0;
   localparam logic [1:0] BOARD_RESET  = 2'h0;
   localparam int STAT_BUSY_BIT    = 0;
   localparam int STAT_PERR_BIT    = 1;
   localparam int STAT_TMO_BIT     = 2;
   localparam int STAT_STATE_LSB   = 4;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum {ST_IDLE, ST_WAIT_DATA, ST_RUN} seq_state_t;
endpackage

/* design/memory_module_op_sequencer.sv */
// memory module operation sequencer with axi4-lite control registers

// Summary of operation
// RULE_01: three chip-select bits pick one of eight chip enables when board matches.
// RULE_02: address bits four to fifteen go to the array.
// RULE_03: read/write command reaches array only while write guard is high.
// RULE_04: array data drivers enabled from D4 to D14 on reads.
// RULE_05: data register captures array output from D4 to D11.
// RULE_06: bus receivers disabled while read data is captured.
// RULE_07: first counted clock with priority and free bus drops busy, sets enable.
// RULE_08: one clock after enable, data-out sets and drives data register.
// RULE_09: return carries destination, source, no-op code and control parity.
// RULE_10: destination is the requester, source is this module.
// RULE_11: write code 01 stores sixteen data bits plus check bit.
// RULE_12: requester sends addressing phase then data phase for writes.
// RULE_13: requester sends no-op code 00 during the write data phase.
// RULE_14: armed write aborts to no-op without data phase in 6.4 ms.
// RULE_15: data phase accepted only on matching codes; starts write, cancels time-out.
// RULE_16: write data locked and presented to array after the match.
// RULE_17: data-phase control or data parity error pulls parity error low, no no-op.
// RULE_18: read-set-ones returns word like a read then writes all ones.
// RULE_19: read-set-ones switches to write at D14, data input ones at D16.
// RULE_20: no-op returns no data.
// RULE_21: address-phase parity no-op still runs read timing, drivers stay off; the code enables the array drivers from D4 to D14 for a no-op too.
// RULE_22: no-op blocks the enable flag so nothing is driven.
// RULE_23: start only when destination equals module number; latch address, show busy.
// RULE_24: odd parity check of address; error flags and forces no-op.
// RULE_25: read completes within four counted clocks, waits while bus busy.
// RULE_26: delay-line instants modelled as timer counts from operation start.
module memory_module_op_sequencer #(
   parameter int TIMEOUT_CYCLES = mem_seq_pkg::WRITE_TIMEOUT_CYCLES
) (
   // clock and reset
   input  wire logic                             clock_i,
   input  wire logic                             rst_b_i,
   // system bus inputs
   input  wire logic                             bus_valid_i,
   input  wire logic [mem_seq_pkg::DEST_W-1:0]   destination_code_i,
   input  wire logic [mem_seq_pkg::SRC_W-1:0]    source_code_i,
   input  wire logic [mem_seq_pkg::OP_W-1:0]     operation_code_i,
   input  wire logic [mem_seq_pkg::DATA_W-1:0]   module_data_lines_i,
   input  wire logic                             address_parity_line_i,
   input  wire logic                             control_parity_bit_i,
   input  wire logic                             bus_priority_i,
   input  wire logic                             bus_busy_i,
   // module level controls
   input  wire logic                             bank_bit_raw_n_i,
   input  wire logic                             write_guard_n_i,
   input  wire logic                             timeout_arm_i,
   // system bus outputs
   output logic                                  ready_busy_o,
   output logic                                  enable_o,
   output logic                                  data_out_o,
   output logic                                  bus_rx_enable_o,
   output logic [mem_seq_pkg::DATA_W-1:0]        module_data_lines_o,
   output logic [mem_seq_pkg::DEST_W-1:0]        destination_code_o,
   output logic [mem_seq_pkg::SRC_W-1:0]         source_code_o,
   output logic [mem_seq_pkg::OP_W-1:0]          operation_code_o,
   output logic                                  control_parity_bit_o,
   output logic                                  parity_error_n_o,
   output logic                                  idle_op_n_o,
   // memory array
   input  wire logic [mem_seq_pkg::DATA_W:0]     array_data_i,
   output logic [7:0]                            chip_enable_o,
   output logic [11:0]                           array_addr_o,
   output logic                                  read_write_select_o,
   output logic                                  array_read_strobe_n_o,
   output logic                                  array_drv_en_o,
   output logic                                  array_data_in_en_o,
   output logic [mem_seq_pkg::DATA_W:0]          array_data_o,
   // axi4-lite slave
   input  wire logic                             s_axi_awvalid,
   output logic                                  s_axi_awready,
   input  wire logic [mem_seq_pkg::AXI_AW-1:0]   s_axi_awaddr,
   input  wire logic                             s_axi_wvalid,
   output logic                                  s_axi_wready,
   input  wire logic [31:0]                      s_axi_wdata,
   input  wire logic [3:0]                       s_axi_wstrb,
   output logic                                  s_axi_bvalid,
   input  wire logic                             s_axi_bready,
   output logic [1:0]                            s_axi_bresp,
   input  wire logic                             s_axi_arvalid,
   output logic                                  s_axi_arready,
   input  wire logic [mem_seq_pkg::AXI_AW-1:0]   s_axi_araddr,
   output logic                                  s_axi_rvalid,
   input  wire logic                             s_axi_rready,
   output logic [31:0]                           s_axi_rdata,
   output logic [1:0]                            s_axi_rresp
);
   import mem_seq_pkg::*;

   // odd parity: true when the word plus its parity bit holds an odd count
   function automatic logic odd_ok(input logic [DATA_W:0] bits);
      odd_ok = ^bits;
   endfunction

   // sequencer state
   seq_state_t              state;
   logic [4:0]              tick;
   logic [OP_W-1:0]         op_r;
   logic [DEST_W-1:0]       dest_r;
   logic [SRC_W-1:0]        src_r;
   logic [DATA_W-1:0]       addr_r;
   logic [DATA_W:0]         data_r;
   logic                    ret_pending;
   logic                    tmo_armed;
   logic [19:0]             tmo_cnt;
   // control registers
   logic [DEST_W-1:0]       modnum;
   logic [1:0]              board_sel;
   logic                    perr_flag;
   logic                    tmo_flag;
   logic                    aw_held;
   logic                    w_held;
   logic [AXI_AW-1:0]       aw_addr_r;
   logic [31:0]             w_data_r;
   logic [3:0]              w_strb_r;

   // incoming transmission decode
   wire logic               dest_hit   = bus_valid_i && (destination_code_i == modnum);
   wire logic               addr_perr  = !odd_ok({module_data_lines_i, address_parity_line_i});
   wire logic               ctl_perr   = !(^{destination_code_i, source_code_i, operation_code_i,
                                             control_parity_bit_i});
   wire logic               start      = (state == ST_IDLE) && dest_hit;                      // RULE_23
   wire logic               start_err  = addr_perr || ctl_perr;                               // RULE_24
   wire logic [OP_W-1:0]    start_op   = start_err ? OP_NOP : operation_code_i;                // RULE_21
   wire logic               phase_hit  = (state == ST_WAIT_DATA) && bus_valid_i &&
                                         (destination_code_i == dest_r) &&
                                         (source_code_i == src_r);                            // RULE_15
   wire logic               data_perr  = !odd_ok({module_data_lines_i, address_parity_line_i});
   wire logic               tmo_fire   = (state == ST_WAIT_DATA) && tmo_armed && !phase_hit &&
                                         (tmo_cnt == 20'(TIMEOUT_CYCLES - 1));                 // RULE_14

   // timing windows in ticks of the operation timer
   wire logic               is_readish = (op_r == OP_READ) || (op_r == OP_RSO) || (op_r == OP_NOP);
   wire logic               in_run     = (state == ST_RUN);
   wire logic               win_drv    = in_run && is_readish &&
                                         (tick >= D4_TICK) && (tick < D14_TICK);               // RULE_04
   wire logic               win_cap    = in_run && is_readish &&
                                         (tick >= D4_TICK) && (tick < D11_TICK);               // RULE_05
   wire logic [4:0]         end_tick   = (op_r == OP_RSO)   ? RSO_END_TICK :
                                         (op_r == OP_WRITE) ? WRITE_END_TICK : READ_END_TICK;  // RULE_26
   wire logic               timer_end  = in_run && (tick >= end_tick);
   wire logic               wr_mode    = (state == ST_WAIT_DATA) || (in_run && op_r == OP_WRITE) ||
                                         (in_run && op_r == OP_RSO && tick >= D14_TICK);       // RULE_19
   wire logic               data_in    = (in_run && op_r == OP_WRITE) ||
                                         (in_run && op_r == OP_RSO && tick >= D16_TICK);       // RULE_19
   wire logic               can_return = in_run && ret_pending && !enable_o && !data_out_o &&
                                         (tick >= READ_DONE_TICK) &&
                                         bus_priority_i && !bus_busy_i;                       // RULE_25
   wire logic               op_done    = timer_end && !ret_pending && !enable_o && !data_out_o;

   // next values for the array and bus outputs
   wire logic               board_hit      = ({addr_r[0], !bank_bit_raw_n_i} == board_sel);
   wire logic               array_active   = (state != ST_IDLE);
   wire logic [7:0]         next_chip_en   = (array_active && board_hit) ?
                                             8'(8'h01 << addr_r[3:1]) : 8'h00;                 // RULE_01
   wire logic               next_rw_sel    = wr_mode && write_guard_n_i;                       // RULE_03
   wire logic               next_strobe_n  = !(in_run && write_guard_n_i);                     // RULE_21
   wire logic [DATA_W:0]    next_arr_data  = (op_r == OP_RSO) ? {(DATA_W+1){1'b1}} : data_r;   // RULE_18
   wire logic               next_ctl_par   = !(^{src_r, modnum[SRC_W-1:0], OP_NOP});           // RULE_09
   wire logic               dphase_err     = phase_hit && (ctl_perr || data_perr);             // RULE_17
   wire logic               any_perr       = (start && start_err) || dphase_err;

   // sequencer state machine
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         state <= ST_IDLE;
         op_r  <= OP_NOP;
         tick  <= 5'h00;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (start) begin
                  op_r  <= start_op;
                  tick  <= 5'h00;
                  state <= (start_op == OP_WRITE) ? ST_WAIT_DATA : ST_RUN;
               end
            end
            ST_WAIT_DATA: begin
               if (phase_hit) begin
                  tick  <= 5'h00;
                  state <= ST_RUN;                                                           // RULE_15
               end else if (tmo_fire) begin
                  op_r  <= OP_NOP;
                  tick  <= 5'h00;
                  state <= ST_RUN;                                                           // RULE_14
               end
            end
            ST_RUN: begin
               if (!timer_end) begin
                  tick <= tick + 5'h01;
               end
               if (op_done) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // latched request fields; codes kept for the data-phase comparison
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         dest_r <= '0;
         src_r  <= '0;
         addr_r <= '0;
      end else if (start) begin
         dest_r <= destination_code_i;
         src_r  <= source_code_i;
         addr_r <= module_data_lines_i;                                                     // RULE_23
      end
   end

   // data register: read capture window or write data lock
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         data_r <= '0;
      end else if (phase_hit) begin
         data_r <= {module_data_lines_i, address_parity_line_i};                            // RULE_16
      end else if (win_cap) begin
         data_r <= array_data_i;                                                            // RULE_05
      end
   end

   // write time-out counter, runs only while armed and waiting
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         tmo_armed <= 1'b0;
         tmo_cnt   <= 20'h00000;
      end else if (start && start_op == OP_WRITE) begin
         tmo_armed <= timeout_arm_i;                                                        // RULE_14
         tmo_cnt   <= 20'h00000;
      end else if (phase_hit || tmo_fire) begin
         tmo_armed <= 1'b0;                                                                 // RULE_15
      end else if (tmo_armed) begin
         tmo_cnt   <= tmo_cnt + 20'h00001;
      end
   end

   // read return: busy drop with enable, then data-out for one clock
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         ret_pending  <= 1'b0;
         ready_busy_o <= 1'b0;
         enable_o     <= 1'b0;
         data_out_o   <= 1'b0;
      end else begin
         if (start) begin
            ready_busy_o <= 1'b1;                                                           // RULE_23
            ret_pending  <= (start_op == OP_READ) || (start_op == OP_RSO);                   // RULE_22
         end else if (can_return) begin
            ready_busy_o <= 1'b0;                                                           // RULE_07
            ret_pending  <= 1'b0;
         end else if (op_done) begin
            ready_busy_o <= 1'b0;
         end
         enable_o   <= can_return;                                                          // RULE_07
         data_out_o <= enable_o;                                                            // RULE_08
      end
   end

   // registered bus drive; fields only meaningful while data-out is high
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         module_data_lines_o  <= '0;
         destination_code_o   <= '0;
         source_code_o        <= '0;
         operation_code_o     <= OP_NOP;
         control_parity_bit_o <= 1'b0;
         bus_rx_enable_o      <= 1'b1;
         parity_error_n_o     <= 1'b1;
         idle_op_n_o          <= 1'b1;
      end else begin
         module_data_lines_o  <= enable_o ? data_r[DATA_W:1] : '0;                          // RULE_08
         destination_code_o   <= enable_o ? DEST_W'(src_r) : '0;                            // RULE_10
         source_code_o        <= enable_o ? SRC_W'(modnum) : '0;                            // RULE_10
         operation_code_o     <= OP_NOP;                                                    // RULE_09
         control_parity_bit_o <= enable_o ? next_ctl_par : 1'b0;                            // RULE_09
         bus_rx_enable_o      <= !win_cap;                                                  // RULE_06
         parity_error_n_o     <= !any_perr;                                                 // RULE_17
         idle_op_n_o          <= !(in_run && op_r == OP_NOP);                               // RULE_20
      end
   end

   // registered array drive
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         chip_enable_o         <= 8'h00;
         array_addr_o          <= 12'h000;
         read_write_select_o   <= 1'b0;
         array_read_strobe_n_o <= 1'b1;
         array_drv_en_o        <= 1'b0;
         array_data_in_en_o    <= 1'b0;
         array_data_o          <= '0;
      end else begin
         chip_enable_o         <= next_chip_en;                                             // RULE_01
         array_addr_o          <= addr_r[15:4];                                             // RULE_02
         read_write_select_o   <= next_rw_sel;                                              // RULE_03
         array_read_strobe_n_o <= next_strobe_n;
         array_drv_en_o        <= win_drv;                                                  // RULE_04
         array_data_in_en_o    <= data_in && write_guard_n_i;                               // RULE_11
         array_data_o          <= next_arr_data;                                            // RULE_18
      end
   end

   // axi write side: address and data taken in either order
   wire logic               wr_go     = aw_held && w_held && !s_axi_bvalid;
   wire logic               wr_ctrl   = wr_go && (aw_addr_r == CTRL_OFFSET);
   wire logic               wr_status = wr_go && (aw_addr_r == STATUS_OFFSET);
   wire logic               wr_known  = wr_ctrl || wr_status;

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr_r    <= '0;
         w_data_r     <= 32'h00000000;
         w_strb_r     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held   <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held   <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held   <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held   <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // each ready only while its own channel holds nothing and no response waits, so one write is in flight
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;

   // control register and sticky status; a new event wins over a clear
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         modnum    <= MODNUM_RESET;
         board_sel <= BOARD_RESET;
         perr_flag <= 1'b0;
         tmo_flag  <= 1'b0;
      end else begin
         if (wr_ctrl && w_strb_r[0]) begin
            modnum <= w_data_r[CTRL_MODNUM_LSB +: DEST_W];
         end
         if (wr_ctrl && w_strb_r[1]) begin
            board_sel <= w_data_r[CTRL_BOARD_LSB +: 2];
         end
         perr_flag <= any_perr || (perr_flag && !(wr_status && w_strb_r[0] && w_data_r[STAT_PERR_BIT]));
         tmo_flag  <= tmo_fire || (tmo_flag && !(wr_status && w_strb_r[0] && w_data_r[STAT_TMO_BIT]));
      end
   end

   // axi read side
   wire logic [31:0]        ctrl_word   = {22'h000000, board_sel, 4'h0, modnum};
   wire logic [31:0]        status_word = {26'h0000000, 2'(state), 1'b0, tmo_flag, perr_flag, ready_busy_o};
   wire logic               rd_ctrl     = (s_axi_araddr == CTRL_OFFSET);
   wire logic               rd_status   = (s_axi_araddr == STATUS_OFFSET);

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_ctrl ? ctrl_word : (rd_status ? status_word : 32'h00000000);
         s_axi_rresp  <= (rd_ctrl || rd_status) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   assign s_axi_arready = !s_axi_rvalid;
endmodule

/* verif/mem_seq_req_model.sv */
// requester model that sends one system bus transmission per call
module mem_seq_req_model (
   input  wire logic        clock_i,
   output logic             v_o, cp_o, ap_o,
   output logic [8:0]       c_o,
   output logic [15:0]      d_o
);
   initial {v_o, cp_o, ap_o, c_o, d_o} = '0;
   // odd parity on codes and data; bad flips the address parity
   task automatic send(input logic [8:0] c, input logic [15:0] d, input logic bad);
      @(posedge clock_i);
      {v_o, c_o, d_o, cp_o, ap_o} <= {1'b1, c, d, ~^c, ~^d ^ bad};
      @(posedge clock_i);
      {v_o, d_o} <= {1'b0, ~d}; // released lines must not keep the word
   endtask
endmodule

/* verif/memory_module_op_sequencer_assertions.sv */
// port-level checks on the operation sequencer
module mem_seq_assertions (
   input wire logic       clock_i, rst_b_i, bus_valid_i, ready_busy_o, enable_o, data_out_o,
   input wire logic       control_parity_bit_o, parity_error_n_o, idle_op_n_o,
   input wire logic [7:0] chip_enable_o,
   input wire logic [3:0] destination_code_o,
   input wire logic [2:0] source_code_o,
   input wire logic [1:0] operation_code_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   AST_ONEHOT: assert property ($onehot0(chip_enable_o)) else $error("chip enables overlap");
   AST_BUSY: assert property ($rose(ready_busy_o) |-> $past(bus_valid_i) || $past(bus_valid_i, 2))
      else $error("busy without request");
   AST_ENPULSE: assert property (enable_o |=> !enable_o) else $error("enable too long");
   AST_DOUT: assert property (data_out_o |-> $past(enable_o) && !enable_o) else $error("data out early");
   AST_OPC: assert property (data_out_o |-> operation_code_o == 2'h0) else $error("return code");
   AST_CPAR: assert property (data_out_o |-> ^{control_parity_bit_o, destination_code_o, source_code_o, operation_code_o})
      else $error("return parity");
   AST_NORET: assert property (!idle_op_n_o |-> !enable_o && !data_out_o) else $error("no-op returned");
   AST_PEPULSE: assert property ($fell(parity_error_n_o) |=> parity_error_n_o) else $error("error pulse");
endmodule
bind memory_module_op_sequencer mem_seq_assertions i_chk (.*);

/* verif/memory_module_op_sequencer_tb.sv */
// self-checking bench for the memory operation sequencer
module memory_module_op_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import mem_seq_pkg::*;
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; $display("BAD %0t %h %h", $time, a, b); end end
`define WT(s) repeat (80) begin @(posedge clock_i); if ((s) === 1'b1) break; end
   logic clock_i = 0, rst_b_i = 0, bus_busy_i = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, bus_priority_i = 1, bank_bit_raw_n_i = 1, write_guard_n_i = 1;
   logic timeout_arm_i = 0, bus_valid_i, address_parity_line_i, control_parity_bit_i, ready_busy_o, enable_o;
   logic data_out_o, bus_rx_enable_o, control_parity_bit_o, parity_error_n_o, idle_op_n_o, read_write_select_o;
   logic array_read_strobe_n_o, array_drv_en_o, array_data_in_en_o, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF, destination_code_i, destination_code_o;
   logic [2:0] source_code_i, source_code_o;
   logic [1:0] operation_code_i, operation_code_o, s_axi_bresp, s_axi_rresp, r;
   logic [15:0] module_data_lines_i, module_data_lines_o;
   logic [16:0] array_data_i = {16'hC3A5, 1'b1}, array_data_o;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [11:0] array_addr_o;
   logic [7:0] chip_enable_o;
   int n_mismatch = 0, checked = 0, cycles = 0;
   memory_module_op_sequencer #(.TIMEOUT_CYCLES(50)) i_dut (.*);
   mem_seq_req_model i_req (.clock_i(clock_i), .v_o(bus_valid_i), .cp_o(control_parity_bit_i),
      .ap_o(address_parity_line_i), .c_o({destination_code_i, source_code_i, operation_code_i}),
      .d_o(module_data_lines_i));
   always #10 clock_i = ~clock_i;
   // hang guard, far above the few hundred cycles the tests need
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         final_report();
      end
   end
   task automatic axw(input logic [3:0] a, input logic [31:0] w);
      @(posedge clock_i);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_awaddr, s_axi_wdata} <= {3'h7, a, w};
      do begin
         @(posedge clock_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [3:0] a);
      @(posedge clock_i);
      {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'h3, a};
      do begin
         @(posedge clock_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      {d, r} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask
   // poll status until idle; one line per finished test
   task automatic idle();
      do axr(STATUS_OFFSET); while (d[5:4] !== 2'h0);
      $display("test done at %0t", $time);
   endtask
   task automatic final_report();
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clock_i);
      rst_b_i <= 1'b1;
      axw(CTRL_OFFSET, 32'h5);
      // read held back while the bus is busy
      bus_busy_i <= 1'b1;
      i_req.send({4'h5, 3'h2, OP_READ}, 16'h00A6, 1'b0);
      @(posedge clock_i);
      `CHK(ready_busy_o, 1'b1)
      repeat (2) @(posedge clock_i);
      `CHK(bus_rx_enable_o, 1'b0)
      repeat (10) @(posedge clock_i);
      `CHK({data_out_o, chip_enable_o, array_addr_o}, {1'b0, 8'h08, 12'h00A})
      bus_busy_i <= 1'b0;
      `WT(data_out_o)
      `CHK({module_data_lines_o, destination_code_o, source_code_o}, {16'hC3A5, 4'h2, 3'h5})
      idle();
      // address parity error: timing runs, nothing returned
      i_req.send({4'h5, 3'h2, OP_READ}, 16'h00A6, 1'b1);
      @(posedge clock_i);
      `CHK(parity_error_n_o, 1'b0)
      `WT(data_out_o)
      `CHK(data_out_o, 1'b0)
      idle();
      // armed write: stray data phase first, then the matching one
      timeout_arm_i <= 1'b1;
      i_req.send({4'h5, 3'h2, OP_WRITE}, 16'h0036, 1'b0);
      i_req.send({4'h5, 3'h3, OP_NOP}, 16'hFFFF, 1'b0);
      i_req.send({4'h5, 3'h2, OP_NOP}, 16'h5A5A, 1'b0);
      `WT(array_data_in_en_o)
      `CHK({read_write_select_o, array_data_o}, {1'b1, 16'h5A5A, 1'b1})
      idle();
      `CHK(d[STAT_TMO_BIT], 1'b0)
      // write left without its data phase times out
      i_req.send({4'h5, 3'h2, OP_WRITE}, 16'h0036, 1'b0);
      repeat (60) @(posedge clock_i);
      idle();
      `CHK(d[STAT_TMO_BIT], 1'b1)
      axr(4'h8);
      `CHK({d, r}, {32'h0, RESP_SLVERR})
      // read-set-ones returns the word, then writes ones
      array_data_i <= {16'h3C5A, 1'b0};
      i_req.send({4'h5, 3'h1, OP_RSO}, 16'h0002, 1'b0);
      `WT(data_out_o)
      `CHK(module_data_lines_o, 16'h3C5A)
      `WT(array_data_in_en_o)
      `CHK(array_data_o, 17'h1FFFF)
      idle();
      final_report();
   end
endmodule
